// ---- logic/ulsr_defines.svh ----
// register offsets, field positions, reset values and timing figures of the uart aux block
`ifndef ULSR_DEFINES_SVH
`define ULSR_DEFINES_SVH
`define ULSR_OFF_THR 4'h0
`define ULSR_OFF_IER 4'h1
`define ULSR_OFF_LCR 4'h3
`define ULSR_OFF_MCR 4'h4
`define ULSR_OFF_DLL 4'h5
`define ULSR_OFF_DLM 4'h6
`define ULSR_OFF_EFR 4'h7
`define ULSR_OFF_AF1 4'h8
`define ULSR_OFF_AF2 4'h9
`define ULSR_OFF_PRE 4'hA
`define ULSR_OFF_STAT 4'hB
`define ULSR_OFF_RXD 4'hC
`define ULSR_MCR_DTR 0
`define ULSR_MCR_RTS 1
`define ULSR_MCR_OP1 2
`define ULSR_MCR_OP2 3
`define ULSR_MCR_LOOP 4
`define ULSR_MCR_CLKSEL 7
`define ULSR_IER_SLEEP 4
`define ULSR_EFR_ENH 4
`define ULSR_EFR_HWFC 6
`define ULSR_AF1_IGNRX 4
`define ULSR_AF2_AUTO485 4
`define ULSR_AF2_INV485 5
`define ULSR_REG_RESET 8'h00
`define ULSR_DIV_RESET 8'h01
`define ULSR_PRESCALE_SLOW 4
`define ULSR_IDLE_CHARS 4
`endif

// ---- logic/ulsr_pkg.sv ----
// types of the uart aux block
package ulsr_pkg;
  typedef enum logic [2:0] {
    ULSR_RUN = 3'b001,
    ULSR_SLEEP = 3'b010,
    ULSR_LOW_POWER_PIN = 3'b100
  } ulsr_pwr_t;
  typedef enum logic [2:0] {
    ULSR_TX_IDLE = 3'b001,
    ULSR_TX_SHIFT = 3'b010,
    ULSR_TX_DONE = 3'b100
  } ulsr_tx_t;
endpackage

// ---- logic/ulsr_top.sv ----
// uart aux logic: baud divider, loopback, sleep, low power, rs485 rts
`include "ulsr_defines.svh"

module ulsr_top #(
  parameter int DIVW = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register port
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // host side status from the rest of the uart
  input wire logic irq_pend_i,
  input wire logic rx_fifo_empty_i,
  input wire logic hw_flow_rts_i,
  // serial and modem pins
  input wire logic rx_pin_i,
  output logic tx_pin_o,
  input wire logic cts_pin_i,
  input wire logic dsr_pin_i,
  input wire logic cd_pin_i,
  input wire logic ri_pin_i,
  output logic rts_pin_o,
  output logic dtr_pin_o,
  output logic irq_o,
  output logic irq_oe_o,
  input wire logic low_power_pin_i,
  // clock gating and status
  output logic uart_clk_en_o,
  output logic host_iso_o,
  output ulsr_pkg::ulsr_pwr_t pwr_state_o
);
  import ulsr_pkg::*;

  // synchronisers for pins: first stage read only by second
  // reset to idle pin levels: low-power pin idles low, else a false low-power follows reset
  logic [5:0] sync1_ff, sync2_ff;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_ff <= 6'h1F;
      sync2_ff <= 6'h1F;
    end else begin
      sync1_ff <= {low_power_pin_i, ri_pin_i, cd_pin_i, dsr_pin_i, cts_pin_i, rx_pin_i};
      sync2_ff <= sync1_ff;
    end
  end

  // registers
  logic [7:0] ier_ff, lcr_ff, mcr_ff, efr_ff, af1_ff, af2_ff, dll_ff, dlm_ff, pre_ff;
  logic [7:0] rxd_ff, rdata_ff;
  logic rxd_valid_ff;
  wire loop_on = mcr_ff[`ULSR_MCR_LOOP];
  ulsr_pwr_t pwr_ff, nxt_pwr;
  wire running = (pwr_ff == ULSR_RUN);
  // host writes are refused while isolated in low power, transmit load included
  wire wr_ok = wr_i && pwr_ff != ULSR_LOW_POWER_PIN;
  wire wr_thr = wr_ok && addr_i == `ULSR_OFF_THR;
  // divisor writes while asleep are the host's fault; they still land
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ier_ff <= `ULSR_REG_RESET;
      lcr_ff <= `ULSR_REG_RESET;
      mcr_ff <= `ULSR_REG_RESET;
      efr_ff <= `ULSR_REG_RESET;
      af1_ff <= `ULSR_REG_RESET;
      af2_ff <= `ULSR_REG_RESET;
      dll_ff <= `ULSR_DIV_RESET;
      dlm_ff <= `ULSR_REG_RESET;
      pre_ff <= `ULSR_REG_RESET;
    end else if (wr_ok) begin
      unique case (addr_i)
        `ULSR_OFF_IER: ier_ff <= wdata_i;
        `ULSR_OFF_LCR: lcr_ff <= wdata_i;
        `ULSR_OFF_MCR: mcr_ff <= wdata_i;
        `ULSR_OFF_EFR: efr_ff <= wdata_i;
        `ULSR_OFF_AF1: af1_ff <= wdata_i;
        `ULSR_OFF_AF2: af2_ff <= wdata_i;
        `ULSR_OFF_DLL: dll_ff <= wdata_i; // low byte of divisor
        `ULSR_OFF_DLM: dlm_ff <= wdata_i; // high byte of divisor
        `ULSR_OFF_PRE: pre_ff <= wdata_i;
        default: ;
      endcase
    end
  end

  // baud tick: prescale 1 or 4, then divisor, then 16x
  wire [DIVW-1:0] divisor = {dlm_ff, dll_ff};
  logic [1:0] pre_cnt_ff;
  logic [DIVW-1:0] div_cnt_ff;
  logic [3:0] x16_ff;
  wire pre_tick = running && (!mcr_ff[`ULSR_MCR_CLKSEL] ||
                  pre_cnt_ff == 2'(`ULSR_PRESCALE_SLOW - 1));
  wire div_tick = pre_tick && div_cnt_ff >= divisor - DIVW'(1);
  wire bit_tick = div_tick && x16_ff == 4'hF;
  // clocks frozen unless running
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pre_cnt_ff <= 2'h0;
      div_cnt_ff <= '0;
      x16_ff <= 4'h0;
    end else if (running) begin
      pre_cnt_ff <= pre_tick ? 2'h0 : pre_cnt_ff + 2'h1;
      if (pre_tick) div_cnt_ff <= div_tick ? '0 : div_cnt_ff + DIVW'(1);
      if (div_tick) x16_ff <= x16_ff + 4'h1;
    end
  end

  // character frame length in bits
  wire [3:0] frame_bits = 4'h1 + 4'h5 + 4'(lcr_ff[1:0]) + 4'(lcr_ff[3]) + 4'(lcr_ff[2]) + 4'h1;

  // transmitter: one shift register, loaded from the holding register write
  ulsr_tx_t tx_st_ff;
  logic [9:0] tx_sh_ff;
  logic [3:0] tx_cnt_ff;
  logic tx_pend_ff;
  logic [7:0] thr_ff;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_st_ff <= ULSR_TX_IDLE;
      tx_sh_ff <= 10'h3FF;
      tx_cnt_ff <= 4'h0;
      tx_pend_ff <= 1'b0;
      thr_ff <= 8'h00;
    end else begin
      if (wr_thr) begin
        tx_pend_ff <= 1'b1;
        thr_ff <= wdata_i;
      end
      unique case (tx_st_ff)
        ULSR_TX_IDLE: if (tx_pend_ff && bit_tick && !wr_thr) begin
          tx_sh_ff <= {1'b1, thr_ff, 1'b0};
          tx_cnt_ff <= frame_bits;
          tx_pend_ff <= 1'b0;
          tx_st_ff <= ULSR_TX_SHIFT;
        end
        ULSR_TX_SHIFT: if (bit_tick) begin
          tx_sh_ff <= {1'b1, tx_sh_ff[9:1]};
          tx_cnt_ff <= tx_cnt_ff - 4'h1;
          if (tx_cnt_ff == 4'h1) tx_st_ff <= ULSR_TX_DONE;
        end
        ULSR_TX_DONE: tx_st_ff <= ULSR_TX_IDLE;
      endcase
    end
  end
  wire tx_bit = (tx_st_ff == ULSR_TX_SHIFT) ? tx_sh_ff[0] : 1'b1;
  wire tx_empty = tx_st_ff == ULSR_TX_IDLE && !tx_pend_ff;

  // receive path: internal loop or pin
  wire rx_bit = loop_on ? tx_bit : sync2_ff[0];
  logic [3:0] rx_cnt_ff;
  logic [7:0] rx_sh_ff;
  logic rx_busy_ff;
  // simple sampler taking one sample per bit tick, with no centring, for the loopback check data
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_busy_ff <= 1'b0;
      rx_cnt_ff <= 4'h0;
      rx_sh_ff <= 8'h00;
      rxd_ff <= 8'h00;
      rxd_valid_ff <= 1'b0;
    end else begin
      if (rd_i && addr_i == `ULSR_OFF_RXD) rxd_valid_ff <= 1'b0;
      if (bit_tick) begin
        if (!rx_busy_ff && !rx_bit) begin
          rx_busy_ff <= 1'b1;
          rx_cnt_ff <= frame_bits - 4'h1;
        end else if (rx_busy_ff) begin
          rx_cnt_ff <= rx_cnt_ff - 4'h1;
          if (rx_cnt_ff > 4'h1) rx_sh_ff <= {rx_bit, rx_sh_ff[7:1]};
          if (rx_cnt_ff == 4'h1) begin
            rx_busy_ff <= 1'b0;
            rxd_ff <= rx_sh_ff;
            rxd_valid_ff <= 1'b1; // set wins over read clear
          end
        end
      end
    end
  end

  // modem inputs, looped or from pins
  wire [3:0] modem_in = loop_on ?
      {mcr_ff[`ULSR_MCR_OP1], mcr_ff[`ULSR_MCR_OP2], mcr_ff[`ULSR_MCR_DTR],
       mcr_ff[`ULSR_MCR_RTS]} : sync2_ff[4:1];
  logic [3:0] modem_prev_ff;
  wire modem_chg = modem_in != modem_prev_ff;

  // rx idle counter in bit times
  logic [7:0] idle_ff;
  wire [7:0] idle_need = 8'(frame_bits) * 8'(`ULSR_IDLE_CHARS);
  wire rx_idle_ok = af1_ff[`ULSR_AF1_IGNRX] || idle_ff >= idle_need;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      idle_ff <= 8'h00;
      modem_prev_ff <= 4'hF; // matches synced idle pins, no false change after reset
    end else begin
      modem_prev_ff <= modem_in;
      if (!rx_bit) idle_ff <= 8'h00;
      else if (bit_tick && idle_ff < idle_need) idle_ff <= idle_ff + 8'h01;
    end
  end

  // power state machine
  wire sleep_en = efr_ff[`ULSR_EFR_ENH] && ier_ff[`ULSR_IER_SLEEP];
  wire sleep_ok = sleep_en && rx_idle_ok && !modem_chg && tx_empty &&
                  !irq_pend_i && rx_fifo_empty_i && !rx_busy_ff;
  wire wake = !rx_bit || wr_thr || modem_chg || !sleep_en;
  always_comb begin
    nxt_pwr = pwr_ff;
    if (sync2_ff[5]) nxt_pwr = ULSR_LOW_POWER_PIN;
    else unique case (pwr_ff)
      ULSR_RUN: if (sleep_ok) nxt_pwr = ULSR_SLEEP;
      ULSR_SLEEP: if (wake) nxt_pwr = ULSR_RUN;
      ULSR_LOW_POWER_PIN: nxt_pwr = ULSR_RUN;
    endcase
  end

  // rts source select and auto rs485 turnaround
  wire auto485 = af2_ff[`ULSR_AF2_AUTO485];
  wire tx_active = !tx_empty || wr_thr;
  wire rts_485 = tx_active ^ !af2_ff[`ULSR_AF2_INV485];
  wire rts_norm = efr_ff[`ULSR_EFR_HWFC] ? hw_flow_rts_i : !mcr_ff[`ULSR_MCR_RTS];
  wire nxt_rts = loop_on ? 1'b1 : (auto485 ? rts_485 : rts_norm);

  // register read mux
  wire [7:0] stat = {3'h0, rxd_valid_ff, tx_empty, pwr_ff};
  logic [7:0] rmux;
  always_comb begin
    unique case (addr_i)
      `ULSR_OFF_IER: rmux = ier_ff;
      `ULSR_OFF_LCR: rmux = lcr_ff;
      `ULSR_OFF_MCR: rmux = mcr_ff;
      `ULSR_OFF_EFR: rmux = efr_ff;
      `ULSR_OFF_AF1: rmux = af1_ff;
      `ULSR_OFF_AF2: rmux = af2_ff;
      `ULSR_OFF_DLL: rmux = dll_ff;
      `ULSR_OFF_DLM: rmux = dlm_ff;
      `ULSR_OFF_PRE: rmux = pre_ff;
      `ULSR_OFF_STAT: rmux = stat;
      `ULSR_OFF_RXD: rmux = rxd_ff;
      default: rmux = 8'h00;
    endcase
  end

  // output flops
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pwr_ff <= ULSR_RUN;
      rdata_ff <= 8'h00;
      tx_pin_o <= 1'b1;
      rts_pin_o <= 1'b1;
      dtr_pin_o <= 1'b1;
      irq_o <= 1'b0;
      irq_oe_o <= 1'b1;
      uart_clk_en_o <= 1'b1;
      host_iso_o <= 1'b0;
    end else begin
      pwr_ff <= nxt_pwr;
      rdata_ff <= rd_i ? rmux : 8'h00;
      tx_pin_o <= loop_on ? 1'b1 : tx_bit; // pin parked high in loopback
      rts_pin_o <= nxt_rts;
      dtr_pin_o <= loop_on ? 1'b1 : !mcr_ff[`ULSR_MCR_DTR];
      irq_o <= irq_pend_i;
      irq_oe_o <= !loop_on; // floated in loopback
      uart_clk_en_o <= nxt_pwr == ULSR_RUN;
      host_iso_o <= nxt_pwr == ULSR_LOW_POWER_PIN;
    end
  end
  assign rdata_o = rdata_ff;
  assign pwr_state_o = pwr_ff;

  // assertions
  irq_float_a: assert property (@(posedge clk_i) disable iff (rst_i)
    loop_on |=> !irq_oe_o) else $error("irq driven in loopback");
  low_power_pin_ent_a: assert property (@(posedge clk_i) disable iff (rst_i)
    sync2_ff[5] |=> pwr_ff == ULSR_LOW_POWER_PIN ##0 host_iso_o) else $error("low power not entered");
  sleep_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(pwr_ff == ULSR_SLEEP) |-> $past(sleep_en)) else $error("sleep without enable");
  sleep_cond_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (pwr_ff == ULSR_RUN && !tx_empty) |=> pwr_ff != ULSR_SLEEP) else $error("sleep with tx busy");
  idle_need_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (pwr_ff == ULSR_RUN && nxt_pwr == ULSR_SLEEP) |-> rx_idle_ok) else $error("rx not idle");
  load_wake_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (pwr_ff == ULSR_SLEEP && wr_thr && !sync2_ff[5]) |=> pwr_ff == ULSR_RUN)
    else $error("no wake on load");
  clk_stop_a: assert property (@(posedge clk_i) disable iff (rst_i)
    pwr_ff != ULSR_RUN |-> !bit_tick ##0 !uart_clk_en_o) else $error("clock runs asleep");
  rts_auto_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (auto485 && !loop_on && !af2_ff[`ULSR_AF2_INV485] && wr_thr) |=> !rts_pin_o)
    else $error("rts not asserted on write");
  rtsinv_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (auto485 && !loop_on && af2_ff[`ULSR_AF2_INV485] && wr_thr) |=> rts_pin_o)
    else $error("inverted rts wrong");
  tx_loop_a: assert property (@(posedge clk_i) disable iff (rst_i)
    loop_on |=> tx_pin_o) else $error("tx pin toggles in loopback");
  sleep_c: cover property (@(posedge clk_i) disable iff (rst_i) pwr_ff == ULSR_SLEEP);
  loop_rx_c: cover property (@(posedge clk_i) disable iff (rst_i) loop_on && $rose(rxd_valid_ff));
  low_power_pin_c: cover property (@(posedge clk_i) disable iff (rst_i) host_iso_o);
endmodule

// ---- verif/ulsr_remote.sv ----
// far-side model: remote station on the serial line and the modem lines
module ulsr_remote (
  // clock for pacing
  input wire logic clk_i,
  // lines toward the uart
  output logic rx_o,
  output logic cts_o,
  output logic dsr_o,
  output logic cd_o,
  output logic ri_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // serial line idles at mark, modem lines start inactive (high)
  initial begin
    rx_o = 1'b1;
    cts_o = 1'b1;
    dsr_o = 1'b1;
    cd_o = 1'b1;
    ri_o = 1'b1;
  end
  // a lone start bit, then back to mark so the line never floats
  task automatic start_bit(input int cycles);
    @(posedge clk_i);
    rx_o <= 1'b0;
    repeat (cycles) @(posedge clk_i);
    rx_o <= 1'b1;
  endtask
  // one modem input changes state
  task automatic flip_cts();
    @(posedge clk_i);
    cts_o <= ~cts_o;
  endtask
endmodule

// ---- verif/ulsr_top_tb.sv ----
// self-checking bench of the uart aux block
`include "ulsr_defines.svh"
module ulsr_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ulsr_pkg::*;
  logic clk_i, rst_i, wr_i, rd_i, irq_pend_i, rx_fifo_empty_i, hw_flow_rts_i, low_power_pin_i;
  logic [3:0] addr_i;
  logic [7:0] wdata_i, rdata_o, data;
  logic rx_w, cts_w, dsr_w, cd_w, ri_w, tx_pin_o, rts_pin_o, dtr_pin_o;
  logic irq_o, irq_oe_o, uart_clk_en_o, host_iso_o, rd_d;
  ulsr_pwr_t pwr_state_o;
  logic [7:0] exp_q[$];
  logic [31:0] rng;
  int fail_count, checks_done, n;
  ulsr_top dut (
    .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .irq_pend_i(irq_pend_i),
    .rx_fifo_empty_i(rx_fifo_empty_i), .hw_flow_rts_i(hw_flow_rts_i), .rx_pin_i(rx_w),
    .tx_pin_o(tx_pin_o), .cts_pin_i(cts_w), .dsr_pin_i(dsr_w), .cd_pin_i(cd_w),
    .ri_pin_i(ri_w), .rts_pin_o(rts_pin_o), .dtr_pin_o(dtr_pin_o), .irq_o(irq_o),
    .irq_oe_o(irq_oe_o), .low_power_pin_i(low_power_pin_i),
    .uart_clk_en_o(uart_clk_en_o), .host_iso_o(host_iso_o), .pwr_state_o(pwr_state_o)
  );
  ulsr_remote remote (
    .clk_i(clk_i), .rx_o(rx_w), .cts_o(cts_w), .dsr_o(dsr_w), .cd_o(cd_w), .ri_o(ri_w)
  );
  // compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    checks_done++;
    if (seen !== want) begin
      fail_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  // register port master: one-cycle strobes
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] want);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    exp_q.push_back(want);
    @(posedge clk_i);
    rd_i <= 1'b0;
  endtask
  task automatic settle();
    repeat (2) @(posedge clk_i);
    #1;
  endtask
  // bounded waits; running out counts as a mismatch and ends the run
  task automatic wait_pwr(input ulsr_pwr_t want, input int bound);
    int k;
    k = 0;
    while (pwr_state_o !== want && k < bound) begin
      @(posedge clk_i);
      #1;
      k++;
    end
    check({5'h00, pwr_state_o}, {5'h00, want});
    if (k >= bound) stop_test();
  endtask
  task automatic wait_for(input int sel, input logic lvl, input int bound, output int cnt);
    cnt = 0;
    while ((sel == 0 ? tx_pin_o : rts_pin_o) !== lvl && cnt < bound) begin
      @(posedge clk_i);
      #1;
      cnt++;
    end
    check({7'h00, cnt < bound}, 8'h01);
    if (cnt >= bound) stop_test();
  endtask
  // read data stand only in the cycle after the strobe, so look mid-cycle
  always @(posedge clk_i) rd_d <= rd_i;
  always @(negedge clk_i) begin
    if (rd_d === 1'b1) begin
      check(rdata_o, exp_q.pop_front());
    end
  end
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    repeat (100000) @(posedge clk_i);
    check(8'h00, 8'h01);
    stop_test();
  end
  initial begin
    {rst_i, rx_fifo_empty_i} = 2'b11;
    {wr_i, rd_i, irq_pend_i, hw_flow_rts_i, low_power_pin_i} = 5'h00;
    addr_i = 4'h0;
    wdata_i = 8'h00;
    rng = 32'h5C02;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    settle();
    check({tx_pin_o, rts_pin_o, dtr_pin_o, irq_oe_o, uart_clk_en_o, host_iso_o, 2'b00}, 8'hF8);
    wr(`ULSR_OFF_MCR, 8'h03);
    settle();
    check({6'h00, rts_pin_o, dtr_pin_o}, 8'h00);
    // loopback: 8 data bits, divisor 1, random bytes
    wr(`ULSR_OFF_LCR, 8'h03);
    wr(`ULSR_OFF_DLL, 8'h01);
    wr(`ULSR_OFF_DLM, 8'h00);
    wr(`ULSR_OFF_MCR, 8'h10);
    settle();
    check({6'h00, irq_oe_o, tx_pin_o}, 8'h01);
    for (int i = 0; i < 2; i++) begin
      rng = xs(rng);
      data = rng[7:0];
      wr(`ULSR_OFF_THR, data);
      repeat (60) @(posedge clk_i);
      #1;
      check({7'h00, tx_pin_o}, 8'h01);
      repeat (300) @(posedge clk_i);
      rd(`ULSR_OFF_STAT, 8'h19);
      rd(`ULSR_OFF_RXD, data);
      rd(`ULSR_OFF_STAT, 8'h09);
    end
    // auto rs485: low while sending, back high after the last bit
    wr(`ULSR_OFF_MCR, 8'h00);
    wr(`ULSR_OFF_AF2, 8'h10);
    wr(`ULSR_OFF_THR, 8'hFF);
    settle();
    check({7'h00, rts_pin_o}, 8'h00);
    wait_for(1, 1'b1, 400, n);
    check({7'h00, n >= 140}, 8'h01);
    // inverted polarity, prescale 4, divisor 2: start bit of 128 clocks
    wr(`ULSR_OFF_AF2, 8'h30);
    wr(`ULSR_OFF_MCR, 8'h80);
    wr(`ULSR_OFF_DLL, 8'h02);
    settle();
    check({7'h00, rts_pin_o}, 8'h00);
    wr(`ULSR_OFF_THR, 8'hFF);
    wait_for(0, 1'b0, 300, n);
    check({7'h00, rts_pin_o}, 8'h01);
    wait_for(0, 1'b1, 400, n);
    check(n[7:0], 8'h80);
    wait_for(1, 1'b0, 1500, n);
    wr(`ULSR_OFF_MCR, 8'h00);
    wr(`ULSR_OFF_DLL, 8'h01);
    wr(`ULSR_OFF_AF2, 8'h00);
    // sleep held off by a pending interrupt
    @(posedge clk_i);
    irq_pend_i <= 1'b1;
    wr(`ULSR_OFF_EFR, 8'h10);
    wr(`ULSR_OFF_AF1, 8'h10);
    wr(`ULSR_OFF_IER, 8'h10);
    repeat (50) @(posedge clk_i);
    #1;
    check({4'h0, irq_o, pwr_state_o}, {4'h0, 1'b1, ULSR_RUN});
    @(posedge clk_i);
    irq_pend_i <= 1'b0;
    wait_pwr(ULSR_SLEEP, 100);
    check({7'h00, uart_clk_en_o}, 8'h00);
    wr(`ULSR_OFF_THR, 8'h55);
    wait_pwr(ULSR_RUN, 20);
    wait_pwr(ULSR_SLEEP, 500);
    fork
      remote.start_bit(16);
      wait_pwr(ULSR_RUN, 20);
    join
    wait_pwr(ULSR_SLEEP, 200);
    remote.flip_cts();
    wait_pwr(ULSR_RUN, 20);
    // without the ignore bit the line must idle four frames first
    wr(`ULSR_OFF_AF1, 8'h00);
    remote.start_bit(16);
    repeat (400) @(posedge clk_i);
    #1;
    check({5'h00, pwr_state_o}, {5'h00, ULSR_RUN});
    wait_pwr(ULSR_SLEEP, 600);
    // loopback feeds modem inputs from control bits: setting op1 must wake the sleeper
    wr(`ULSR_OFF_MCR, 8'h10);
    settle();
    wait_pwr(ULSR_SLEEP, 20);
    wr(`ULSR_OFF_MCR, 8'h14);
    wait_pwr(ULSR_RUN, 20);
    wr(`ULSR_OFF_MCR, 8'h00);
    wr(`ULSR_OFF_EFR, 8'h00);
    repeat (50) @(posedge clk_i);
    #1;
    check({5'h00, pwr_state_o}, {5'h00, ULSR_RUN});
    // low power pin wins; writes meanwhile are refused
    @(posedge clk_i);
    low_power_pin_i <= 1'b1;
    wait_pwr(ULSR_LOW_POWER_PIN, 10);
    check({6'h00, host_iso_o, uart_clk_en_o}, 8'h02);
    wr(`ULSR_OFF_MCR, 8'h03);
    @(posedge clk_i);
    low_power_pin_i <= 1'b0;
    wait_pwr(ULSR_RUN, 10);
    settle();
    check({6'h00, rts_pin_o, dtr_pin_o}, 8'h03);
    stop_test();
  end
endmodule
